// ### rtl/rap_pkg.sv
// Purpose: shared constants for the aux PLL and status page register bank
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   printed offsets are not all multiples of four, so each is an index
package rap_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] RAP_IDX_AUX_B_A_HI   = 8'h1b;
  localparam logic [7:0] RAP_IDX_AUX_A_LO     = 8'h1c;
  localparam logic [7:0] RAP_IDX_THRESHOLDS   = 8'h1d;
  localparam logic [7:0] RAP_IDX_MIXER_TRIM   = 8'h22;
  localparam logic [7:0] RAP_IDX_PAGE_SEL     = 8'h29;
  localparam logic [7:0] RAP_IDX_RSSI_VIEW    = 8'h2b;
  localparam logic [7:0] RAP_IDX_CAL_VIEW     = 8'h2c;
  localparam logic [7:0] RAP_IDX_ADC_VIEW     = 8'h2d;
  // reset values
  localparam logic [7:0] RAP_RST_AUX_B_A_HI   = 8'h61;
  localparam logic [7:0] RAP_RST_AUX_A_LO     = 8'h18;
  localparam logic [7:0] RAP_RST_THRESHOLDS   = 8'h00;
  localparam logic [7:0] RAP_RST_MIXER_TRIM   = 8'h00;
  localparam logic [7:0] RAP_RST_PAGE_SEL     = 8'h00;
  // field positions
  localparam int RAP_B_LSB_POS    = 2;
  localparam int RAP_CHAN_TH_POS  = 4;
  localparam int RAP_ADC_PAGE_POS = 6;
  localparam int RAP_CAL_PAGE_POS = 4;
  // prescaler moduli
  localparam logic [4:0] RAP_PRESC_LOW  = 5'h1f;   // terminal count for 32
  localparam logic [5:0] RAP_PRESC_HIGH = 6'h20;   // terminal count for 33
  // rssi page codes
  typedef enum logic [3:0] {
    RAP_PG_REALTIME = 4'h0,
    RAP_PG_QUIET    = 4'h2,
    RAP_PG_PILOT    = 4'h4,
    RAP_PG_DATA     = 4'h6,
    RAP_PG_PEAK     = 4'h8,
    RAP_PG_COL_TIME = 4'hc,
    RAP_PG_COL_LEN  = 4'hd,
    RAP_PG_ERR_TIME = 4'he
  } rap_page_t;
endpackage : rap_pkg

// ### rtl/rap_dual_mod_div.sv
// Purpose: dual-modulus 32/33 divider, N = B*32 + A*33
// Assumes: vco_tick is a one-cycle enable at the divided input rate
// Notes:   A cycles at 33 then B cycles at 32; div_out pulses once per N ticks
`timescale 1ns/1ps
`default_nettype none
module rap_dual_mod_div (
  input  wire logic       pclk,      // core clock
  input  wire logic       presetn,   // async reset, active low
  input  wire logic       vco_tick,  // input-rate enable
  input  wire logic [9:0] div_a,     // count of divide-by-33 passes
  input  wire logic [9:0] div_b,     // count of divide-by-32 passes
  output logic            div_out    // one pulse per full N count
);
  import rap_pkg::*;
  logic [5:0] pre_r, pre_nxt;        // prescaler position
  logic [9:0] cnt_r, cnt_nxt;        // passes done in current phase
  logic       in_a_r, in_a_nxt;      // high while in the 33 phase
  logic       out_r, out_nxt;        // registered output pulse
  logic       pre_end;               // prescaler wraps this tick

  // next-state: phase A uses modulus 33, phase B modulus 32
  always_comb begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    in_a_nxt = in_a_r;
    out_nxt = 1'b0;
    pre_end = in_a_r ? (pre_r == RAP_PRESC_HIGH) : (pre_r == {1'b0, RAP_PRESC_LOW});
    if (vco_tick) begin
      pre_nxt = pre_end ? 6'h00 : pre_r + 6'h01;
      if (pre_end) begin
        if (in_a_r && (cnt_r + 10'h001 >= div_a)) begin
          in_a_nxt = 1'b0;
          cnt_nxt = 10'h000;
          if (div_b == 10'h000) begin
            in_a_nxt = 1'b1;
            out_nxt = 1'b1;
          end
        end else if (!in_a_r && (cnt_r + 10'h001 >= div_b)) begin
          in_a_nxt = (div_a != 10'h000);
          cnt_nxt = 10'h000;
          out_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 10'h001;
        end
      end
    end
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 6'h00;
      cnt_r <= 10'h000;
      in_a_r <= 1'b1;
      out_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      in_a_r <= in_a_nxt;
      out_r <= out_nxt;
    end
  end

  assign div_out = out_r;
endmodule : rap_dual_mod_div
`default_nettype wire

// ### rtl/rap_regs.sv
// Purpose: aux PLL divider, thresholds, mixer trim and status page registers
// Assumes: APB slave at 10 MHz, zero wait states, inputs synchronous to pclk
// Notes:   view registers at 2Bh..2Dh are read-only and steered by the page select
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module rap_regs (
  input  wire logic        pclk,               // core clock, 10 MHz
  input  wire logic        presetn,            // async reset, active low
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb access phase
  input  wire logic        pwrite,             // apb direction
  input  wire logic [11:0] paddr,              // apb byte address
  input  wire logic [31:0] pwdata,             // apb write data
  output logic             pready,             // apb ready, always high
  output logic [31:0]      prdata,             // apb read data
  output logic             pslverr,            // apb error on unmapped
  input  wire logic        vco_tick,           // aux vco rate enable
  output logic             aux_div_out,        // aux divider output pulse
  output logic [9:0]       aux_div_a,          // aux A value
  output logic [9:0]       aux_div_b,          // aux B value (low six held here)
  input  wire logic [3:0]  rssi_i_now,         // realtime I rssi
  input  wire logic [3:0]  rssi_q_now,         // realtime Q rssi
  input  wire logic        store_rssi_cmd,     // store-RSSI direct command pulse
  input  wire logic        pilot_strobe,       // pilot measurement point
  input  wire logic        data_strobe,        // second byte measurement point
  input  wire logic        frame_start,        // receive frame begins
  input  wire logic        bit_tick,           // one received bit
  input  wire logic        proto_violation,    // protocol violation seen
  input  wire logic [7:0]  cal_view_data [4],  // 2Ch views by page
  input  wire logic [7:0]  adc_view_data [4],  // 2Dh views by page
  output logic             chan_pick_valid,    // measurement counts for pick
  output logic             chan_pick_q,        // Q stronger than I
  output logic             collision_seen,     // collision threshold exceeded
  output logic [1:0]       mixer_bias_trim,    // bias decrease code
  output logic [2:0]       mixer_sink_adj,     // load stage current
  output logic [2:0]       mixer_range_sel,    // single-ended range
  output logic             mixer_low_supply,   // differential low supply bias
  output logic             range_boost,        // differential range boost
  input  wire logic        mixer_diff_mode     // mixer runs differential
);
  import rap_pkg::*;

  // software registers
  logic [7:0] aux_ba_r, aux_ba_nxt;        // 1Bh
  logic [7:0] aux_alo_r, aux_alo_nxt;      // 1Ch
  logic [7:0] thr_r, thr_nxt;              // 1Dh
  logic [7:0] mix_r, mix_nxt;              // 22h
  logic [7:0] page_r, page_nxt;            // 29h
  // captured rssi snapshots, Q in high nibble
  logic [7:0] quiet_r, quiet_nxt;
  logic [7:0] pilot_r, pilot_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] peak_r, peak_nxt;
  // collision and error timing
  logic [7:0] bitcnt_r, bitcnt_nxt;        // received bits in frame
  logic [7:0] col_time_r, col_time_nxt;    // bit time of first exceed
  logic [7:0] col_len_r, col_len_nxt;      // bits spent above threshold
  logic       col_hit_r, col_hit_nxt;      // first exceed already logged
  logic [7:0] err_time_r, err_time_nxt;    // bit time of first violation
  logic       err_hit_r, err_hit_nxt;      // first violation already logged

  logic        wr_en;                       // write in access phase
  logic        rd_en;                       // read in access phase
  logic [9:0]  idx;                         // word index from address
  logic        mapped;                      // index hits a register
  logic [7:0]  rd_byte;                     // selected read byte
  logic [7:0]  rssi_now;                    // packed realtime reading
  logic [3:0]  chan_th;                     // channel pick threshold
  logic [3:0]  col_th;                      // collision threshold
  logic [3:0]  rssi_page;                   // 2Bh page code
  logic [1:0]  cal_page;                    // 2Ch page
  logic [1:0]  adc_page;                    // 2Dh page
  logic        col_now;                     // either channel above threshold

  // apb decode; zero wait states keep the slave simple
  assign idx    = paddr[11:2];
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (idx == {2'b00, RAP_IDX_AUX_B_A_HI}) || (idx == {2'b00, RAP_IDX_AUX_A_LO})
               || (idx == {2'b00, RAP_IDX_THRESHOLDS}) || (idx == {2'b00, RAP_IDX_MIXER_TRIM})
               || (idx == {2'b00, RAP_IDX_PAGE_SEL})   || (idx == {2'b00, RAP_IDX_RSSI_VIEW})
               || (idx == {2'b00, RAP_IDX_CAL_VIEW})   || (idx == {2'b00, RAP_IDX_ADC_VIEW});
  assign pslverr = psel && penable && !mapped;

  // field extraction
  assign rssi_now  = {rssi_q_now, rssi_i_now};
  assign chan_th   = thr_r[RAP_CHAN_TH_POS +: 4];
  assign col_th    = thr_r[3:0];
  assign rssi_page = page_r[3:0];
  assign cal_page  = page_r[RAP_CAL_PAGE_POS +: 2];
  assign adc_page  = page_r[RAP_ADC_PAGE_POS +: 2];
  assign col_now   = (rssi_i_now > col_th) || (rssi_q_now > col_th);

  // divider values out to the aux PLL
  assign aux_div_a = {aux_ba_r[1:0], aux_alo_r};
  assign aux_div_b = {4'h0, aux_ba_r[7:RAP_B_LSB_POS]};

  // channel pick qualification
  assign chan_pick_valid = (rssi_i_now > chan_th) || (rssi_q_now > chan_th);
  assign chan_pick_q     = rssi_q_now > rssi_i_now;
  assign collision_seen  = col_hit_r;

  // mixer trim fields; bit 2 has no effect in differential mode
  assign mixer_bias_trim  = mix_r[7:6];
  assign mixer_sink_adj   = mix_r[5:3];
  assign mixer_range_sel  = mixer_diff_mode ? 3'h0 : mix_r[2:0];
  assign mixer_low_supply = mixer_diff_mode && mix_r[1];
  assign range_boost      = mixer_diff_mode && mix_r[0];

  // software register writes, byte in the low lane
  always_comb begin
    aux_ba_nxt  = aux_ba_r;
    aux_alo_nxt = aux_alo_r;
    thr_nxt     = thr_r;
    mix_nxt     = mix_r;
    page_nxt    = page_r;
    if (wr_en) begin
      unique case (idx[7:0])
        RAP_IDX_AUX_B_A_HI: aux_ba_nxt  = pwdata[7:0];
        RAP_IDX_AUX_A_LO:   aux_alo_nxt = pwdata[7:0];
        RAP_IDX_THRESHOLDS: thr_nxt     = pwdata[7:0];
        RAP_IDX_MIXER_TRIM: mix_nxt     = pwdata[7:0];
        RAP_IDX_PAGE_SEL:   page_nxt    = pwdata[7:0];
        default: ;                                                    // read-only or unmapped
      endcase
      if (idx[9:8] != 2'b00) begin
        aux_ba_nxt  = aux_ba_r;
        aux_alo_nxt = aux_alo_r;
        thr_nxt     = thr_r;
        mix_nxt     = mix_r;
        page_nxt    = page_r;
      end
    end
  end

  // rssi snapshots; peak keeps the larger nibble per channel
  always_comb begin
    quiet_nxt = store_rssi_cmd ? rssi_now : quiet_r;
    pilot_nxt = pilot_strobe ? rssi_now : pilot_r;
    data_nxt  = data_strobe ? rssi_now : data_r;
    peak_nxt  = peak_r;
    if (frame_start) begin
      peak_nxt = rssi_now;
    end else begin
      if (rssi_q_now > peak_r[7:4]) peak_nxt[7:4] = rssi_q_now;
      if (rssi_i_now > peak_r[3:0]) peak_nxt[3:0] = rssi_i_now;
    end
  end

  // frame timing: counts saturate rather than wrap to keep firsts honest
  always_comb begin
    bitcnt_nxt   = bitcnt_r;
    col_time_nxt = col_time_r;
    col_len_nxt  = col_len_r;
    col_hit_nxt  = col_hit_r;
    err_time_nxt = err_time_r;
    err_hit_nxt  = err_hit_r;
    if (frame_start) begin
      // a hit on the opening cycle still counts, logged at bit zero
      bitcnt_nxt   = 8'h00;
      col_time_nxt = 8'h00;
      col_len_nxt  = 8'h00;
      col_hit_nxt  = col_now;
      err_time_nxt = 8'h00;
      err_hit_nxt  = proto_violation;
    end else begin
      if (bit_tick && bitcnt_r != 8'hff) bitcnt_nxt = bitcnt_r + 8'h01;
      if (col_now && !col_hit_r) begin
        col_hit_nxt  = 1'b1;
        col_time_nxt = bitcnt_r;
      end
      if (col_now && bit_tick && col_len_r != 8'hff) col_len_nxt = col_len_r + 8'h01;
      if (proto_violation && !err_hit_r) begin
        err_hit_nxt  = 1'b1;
        err_time_nxt = bitcnt_r;
      end
    end
  end

  // read mux; views are pure selects so a read disturbs nothing
  always_comb begin
    rd_byte = 8'h00;
    if (idx[9:8] == 2'b00) begin
      unique case (idx[7:0])
        RAP_IDX_AUX_B_A_HI: rd_byte = aux_ba_r;
        RAP_IDX_AUX_A_LO:   rd_byte = aux_alo_r;
        RAP_IDX_THRESHOLDS: rd_byte = thr_r;
        RAP_IDX_MIXER_TRIM: rd_byte = mix_r;
        RAP_IDX_PAGE_SEL:   rd_byte = page_r;
        RAP_IDX_CAL_VIEW:   rd_byte = cal_view_data[cal_page];
        RAP_IDX_ADC_VIEW:   rd_byte = adc_view_data[adc_page];
        RAP_IDX_RSSI_VIEW: begin
          unique case (rssi_page)
            RAP_PG_REALTIME: rd_byte = rssi_now;
            RAP_PG_QUIET:    rd_byte = quiet_r;
            RAP_PG_PILOT:    rd_byte = pilot_r;
            RAP_PG_DATA:     rd_byte = data_r;
            RAP_PG_PEAK:     rd_byte = peak_r;
            RAP_PG_COL_TIME: rd_byte = col_time_r;
            RAP_PG_COL_LEN:  rd_byte = col_len_r;
            RAP_PG_ERR_TIME: rd_byte = err_time_r;
            default:         rd_byte = 8'h00;
          endcase
        end
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_ba_r   <= RAP_RST_AUX_B_A_HI;
      aux_alo_r  <= RAP_RST_AUX_A_LO;
      thr_r      <= RAP_RST_THRESHOLDS;
      mix_r      <= RAP_RST_MIXER_TRIM;
      page_r     <= RAP_RST_PAGE_SEL;
      quiet_r    <= 8'h00;
      pilot_r    <= 8'h00;
      data_r     <= 8'h00;
      peak_r     <= 8'h00;
      bitcnt_r   <= 8'h00;
      col_time_r <= 8'h00;
      col_len_r  <= 8'h00;
      col_hit_r  <= 1'b0;
      err_time_r <= 8'h00;
      err_hit_r  <= 1'b0;
      prdata     <= 32'h0000_0000;
    end else begin
      aux_ba_r   <= aux_ba_nxt;
      aux_alo_r  <= aux_alo_nxt;
      thr_r      <= thr_nxt;
      mix_r      <= mix_nxt;
      page_r     <= page_nxt;
      quiet_r    <= quiet_nxt;
      pilot_r    <= pilot_nxt;
      data_r     <= data_nxt;
      peak_r     <= peak_nxt;
      bitcnt_r   <= bitcnt_nxt;
      col_time_r <= col_time_nxt;
      col_len_r  <= col_len_nxt;
      col_hit_r  <= col_hit_nxt;
      err_time_r <= err_time_nxt;
      err_hit_r  <= err_hit_nxt;
      // read data registered in setup so it stands through the access phase
      if (psel && !penable && !pwrite) prdata <= {24'h00_0000, rd_byte};
    end
  end

  // aux divider instance
  rap_dual_mod_div u_aux_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .vco_tick (vco_tick),
    .div_a    (aux_div_a),
    .div_b    (aux_div_b),
    .div_out  (aux_div_out)
  );

  // assertions
  property p_div_fields;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == {RAP_IDX_AUX_B_A_HI, 2'b00} && paddr[11:10] == 2'b00)
        |=> (aux_div_b[5:0] == $past(pwdata[7:2]) && aux_div_a[9:8] == $past(pwdata[1:0]));
  endproperty
  a_div_fields: assert property (p_div_fields) else $error("1Bh fields wrong");

  property p_a_low;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == {2'b00, RAP_IDX_AUX_A_LO, 2'b00}) |=> aux_div_a[7:0] == $past(pwdata[7:0]);
  endproperty
  a_a_low: assert property (p_a_low) else $error("1Ch A low wrong");

  property p_pick;
    @(posedge pclk) disable iff (!presetn)
      (rssi_i_now <= thr_r[7:4] && rssi_q_now <= thr_r[7:4]) |-> !chan_pick_valid;
  endproperty
  a_pick: assert property (p_pick) else $error("pick valid below threshold");

  property p_col_first;
    @(posedge pclk) disable iff (!presetn)
      (!frame_start && col_now && !col_hit_r) |=> (col_hit_r && col_time_r == $past(bitcnt_r));
  endproperty
  a_col_first: assert property (p_col_first) else $error("collision onset lost");

  property p_mix;
    @(posedge pclk) disable iff (!presetn)
      mixer_diff_mode |-> (range_boost == mix_r[0] && mixer_low_supply == mix_r[1]);
  endproperty
  a_mix: assert property (p_mix) else $error("diff mixer bits wrong");

  property p_quiet;
    @(posedge pclk) disable iff (!presetn)
      store_rssi_cmd |=> quiet_r == {$past(rssi_q_now), $past(rssi_i_now)};
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet rssi not stored");

  property p_err_hold;
    @(posedge pclk) disable iff (!presetn)
      (err_hit_r && !frame_start) |=> $stable(err_time_r);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error time moved");

  property p_unused;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == {2'b00, RAP_IDX_RSSI_VIEW, 2'b00}
       && (rssi_page[0] || rssi_page == 4'ha) && rssi_page[3:2] != 2'b11)
        |=> prdata == 32'h0000_0000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused page not zero");
endmodule : rap_regs
`default_nettype wire

// ### test/rap_regs_test.sv
// Purpose: self-checking bench for the aux PLL and status page register bank
// Assumes: zero-wait APB slave; view sources and rssi levels driven by the bench
// Notes:   divider runs with small A and B so a full count stays short
`timescale 1ns/1ps
`default_nettype none
module rap_regs_test;
  import rap_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite; // clock, reset, apb control
  logic [11:0] paddr;                                // apb byte address
  logic [31:0] pwdata, prdata;                       // apb data
  logic        pready, pslverr, vco_tick, aux_div_out; // apb answer, divider
  logic [9:0]  aux_div_a, aux_div_b;                 // divider values out
  logic [3:0]  rq, ri;                               // rssi levels in
  logic        st_cmd, pil, dat, fst, btk, viol;     // event pulses in
  logic [7:0]  cal_v [4];                            // 2Ch view sources
  logic [7:0]  adc_v [4];                            // 2Dh view sources
  logic        pk_v, pk_q, col, mlow, mboost, mdiff; // pick, collision, mixer
  logic [1:0]  mbias;                                // mixer bias trim
  logic [2:0]  msink, mrange;                        // mixer sink and range
  int          num_errors, comparisons;              // report counters

  rap_regs rap_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .vco_tick(vco_tick), .aux_div_out(aux_div_out),
    .aux_div_a(aux_div_a), .aux_div_b(aux_div_b), .rssi_i_now(ri), .rssi_q_now(rq),
    .store_rssi_cmd(st_cmd), .pilot_strobe(pil), .data_strobe(dat), .frame_start(fst),
    .bit_tick(btk), .proto_violation(viol), .cal_view_data(cal_v),
    .adc_view_data(adc_v), .chan_pick_valid(pk_v), .chan_pick_q(pk_q),
    .collision_seen(col), .mixer_bias_trim(mbias), .mixer_sink_adj(msink),
    .mixer_range_sel(mrange), .mixer_low_supply(mlow), .range_boost(mboost),
    .mixer_diff_mode(mdiff));

  // 10 MHz core clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // compare and count; four-state equality so unknowns never match
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // verdict and end of run
  task end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  // one apb transfer; entered just after a rising edge, leaves one idle edge
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, {24'h0, v}, d, e);
  endtask : wr

  // read and compare one register; mapped places give no error
  task rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0, d, e);
    check(d, {24'h0, exp});
    check({31'h0, e}, 32'h0);
  endtask : rchk

  // count edges between the second and third divider pulses
  task div_gap(output int g);
    int n, k;
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (aux_div_out !== 1'b1 && n < 20000);
    end
    g = n;
  endtask : div_gap

  // hold bit_tick high for n edges
  task bits(input int n);
    btk <= 1'b1;
    repeat (n) @(posedge pclk);
    btk <= 1'b0;
    @(posedge pclk);
  endtask : bits

  // hang guard, well above the expected run length
  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    end_sim;
  end

  initial begin : main
    logic [31:0] d;
    logic        e;
    int          g, k;
    {presetn, psel, penable, pwrite, paddr, pwdata, vco_tick} = '0;
    {rq, ri, st_cmd, pil, dat, fst, btk, viol, mdiff} = '0;
    num_errors = 0;
    comparisons = 0;
    for (k = 0; k < 4; k++) begin
      cal_v[k] = 8'h30 + 8'(k);
      adc_v[k] = 8'hc5 - 8'(k);
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(RAP_IDX_AUX_B_A_HI, 8'h61);
    rchk(RAP_IDX_AUX_A_LO, 8'h18);
    check({22'h0, aux_div_a}, 32'h118);
    check({22'h0, aux_div_b}, 32'h18);
    // B=1, A=1 gives N=65 input ticks per output pulse
    wr(RAP_IDX_AUX_B_A_HI, 8'h04);
    wr(RAP_IDX_AUX_A_LO, 8'h01);
    check({22'h0, aux_div_a}, 32'h1);
    check({22'h0, aux_div_b}, 32'h1);
    vco_tick <= 1'b1;
    div_gap(g);
    check(32'(g), 32'd65);
    vco_tick <= 1'b0;
    // channel threshold 5, collision threshold 3
    wr(RAP_IDX_THRESHOLDS, 8'h53);
    rchk(RAP_IDX_THRESHOLDS, 8'h53);
    rq <= 4'h9;
    ri <= 4'h1;
    repeat (3) @(posedge pclk);
    check({30'h0, pk_v, pk_q}, 32'h3);
    check({31'h0, col}, 32'h1);
    // Q at the channel threshold gives no pick; the collision flag holds for the frame
    rq <= 4'h5;
    ri <= 4'h3;
    repeat (3) @(posedge pclk);
    check({31'h0, pk_v}, 32'h0);
    check({31'h0, col}, 32'h1);
    // a new frame with both levels equal to the collision threshold sees no collision
    rq <= 4'h3;
    fst <= 1'b1;
    @(posedge pclk);
    fst <= 1'b0;
    repeat (3) @(posedge pclk);
    check({31'h0, col}, 32'h0);
    // mixer trim in both mixer modes
    mdiff <= 1'b1;
    wr(RAP_IDX_MIXER_TRIM, 8'hff);
    check({22'h0, mbias, msink, mrange, mlow, mboost}, 32'h3e3);
    wr(RAP_IDX_MIXER_TRIM, 8'h02);
    check({22'h0, mbias, msink, mrange, mlow, mboost}, 32'h002);
    mdiff <= 1'b0;
    wr(RAP_IDX_MIXER_TRIM, 8'h05);
    check({22'h0, mbias, msink, mrange, mlow, mboost}, 32'h014);
    // every page of the two calibration and adc views
    for (k = 0; k < 4; k++) begin
      wr(RAP_IDX_PAGE_SEL, {2'(k), 2'(3 - k), 4'h0});
      rchk(RAP_IDX_ADC_VIEW, adc_v[k]);
      rchk(RAP_IDX_CAL_VIEW, cal_v[3 - k]);
    end
    // realtime rssi, and a write to the read-only view is dropped
    wr(RAP_IDX_PAGE_SEL, 8'h00);
    rq <= 4'ha;
    ri <= 4'h6;
    wr(RAP_IDX_RSSI_VIEW, 8'hff);
    rchk(RAP_IDX_RSSI_VIEW, 8'ha6);
    // captured levels: quiet, pilot, data, then peak over a frame
    rq <= 4'h1; ri <= 4'hc; st_cmd <= 1'b1; @(posedge pclk); st_cmd <= 1'b0;
    rq <= 4'h3; ri <= 4'h9; pil <= 1'b1; @(posedge pclk); pil <= 1'b0;
    rq <= 4'h8; ri <= 4'h2; dat <= 1'b1; @(posedge pclk); dat <= 1'b0;
    rq <= 4'h2; ri <= 4'h5; fst <= 1'b1; @(posedge pclk); fst <= 1'b0;
    @(posedge pclk);
    rq <= 4'h7; ri <= 4'h1; @(posedge pclk);
    rq <= 4'h0; ri <= 4'h0; @(posedge pclk);
    wr(RAP_IDX_PAGE_SEL, 8'h02);
    rchk(RAP_IDX_RSSI_VIEW, 8'h1c);
    wr(RAP_IDX_PAGE_SEL, 8'h04);
    rchk(RAP_IDX_RSSI_VIEW, 8'h39);
    wr(RAP_IDX_PAGE_SEL, 8'h06);
    rchk(RAP_IDX_RSSI_VIEW, 8'h82);
    wr(RAP_IDX_PAGE_SEL, 8'h08);
    rchk(RAP_IDX_RSSI_VIEW, 8'h75);
    // collision onset after 3 bits, lasting 2; violation after 4 more bits
    fst <= 1'b1; @(posedge pclk); fst <= 1'b0;
    bits(3);
    rq <= 4'h9;
    bits(2);
    rq <= 4'h0;
    bits(4);
    viol <= 1'b1; @(posedge pclk); viol <= 1'b0;
    bits(2);
    wr(RAP_IDX_PAGE_SEL, 8'h0c);
    rchk(RAP_IDX_RSSI_VIEW, 8'd3);
    wr(RAP_IDX_PAGE_SEL, 8'h0d);
    rchk(RAP_IDX_RSSI_VIEW, 8'd2);
    wr(RAP_IDX_PAGE_SEL, 8'h0e);
    rchk(RAP_IDX_RSSI_VIEW, 8'd9);
    wr(RAP_IDX_PAGE_SEL, 8'h01);
    rchk(RAP_IDX_RSSI_VIEW, 8'h00);
    rchk(RAP_IDX_PAGE_SEL, 8'h01);
    // unmapped place: error answer, zero data, no write lands
    wr(8'h1e, 8'h5a);
    apb(1'b0, 8'h1e, 32'h0, d, e);
    check(d, 32'h0);
    check({31'h0, e}, 32'h1);
    rchk(RAP_IDX_THRESHOLDS, 8'h53);
    end_sim;
  end
endmodule : rap_regs_test
`default_nettype wire
